// ### core/wdt_pkg.sv
// Types used by the watchdog top module.
// Assumes nothing beyond a SystemVerilog compiler.
package wdt_pkg;

  // Power state of the core as seen by the watchdog
  typedef enum logic [1:0] {PM_RUN, PM_SLEEP, PM_IDLE} powerMode_t;

  // Whole state of the watchdog top module
  typedef struct packed {
    logic softEnable;
    logic timeoutFlag;
    logic sleepFlag;
    logic idleFlag;
    logic [7:0] cfg;
    logic [15:0] postCnt;
    powerMode_t mode;
    logic resetPulse;
    logic wakePulse;
    logic rcClockOn;
    logic [15:0] rdData;
  } wdtState_t;

endpackage

// ### core/wdt_prescaler.sv
// Low-power RC tick generator and 5/7-bit prescaler of the watchdog.
// Assumes clk_sys at 100 MHz; run, clear and longMode come from logic on clk_sys.
`timescale 1ns/1ns
`include "wdt_regs.svh"

module wdt_prescaler #(
  parameter int RC_CYCLES = `WDT_RC_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Control
  input wire logic run,
  input wire logic clear,
  input wire logic longMode,
  // Prescaler result
  output logic preDone,
  output logic [6:0] preCount
);

  localparam int DW = $clog2(RC_CYCLES);

  typedef struct packed {
    logic [DW-1:0] rcDiv;
    logic [6:0] preCnt;
    logic done;
  } preState_t;

  preState_t s_r;
  preState_t s_nxt;
  logic [6:0] preMax;

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (RC_CYCLES < 2) begin : g_bad_div
    $error("wdt_prescaler: RC_CYCLES must be at least 2");
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Divide the system clock down to the RC rate, then by 32 or 128
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    preMax = longMode ? `WDT_PRE_LONG_MAX : `WDT_PRE_SHORT_MAX; // see R2, see R18
    if (clear) begin
      s_nxt.rcDiv = '0;
      s_nxt.preCnt = 7'h00;
    end else if (run) begin // see R1
      if (s_r.rcDiv == DW'(RC_CYCLES - 1)) begin
        s_nxt.rcDiv = '0;
        if (s_r.preCnt >= preMax) begin // see R3
          s_nxt.preCnt = 7'h00;
          s_nxt.done = 1'b1;
        end else begin
          s_nxt.preCnt = s_r.preCnt + 7'h01;
        end
      end else begin
        s_nxt.rcDiv = s_r.rcDiv + DW'(1);
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0; // see R5
    end else begin
      s_r <= s_nxt;
    end
  end

  assign preDone = s_r.done;
  assign preCount = s_r.preCnt;

endmodule

// ### core/wdt_regs.svh
// Register offsets, field positions, reset values and timing counts of the watchdog.
// Assumes inclusion by bare name from the core/ folder; definitions only.
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define WDT_RSTCTL_ADDR 8'h00
`define WDT_CFG_ADDR 8'h04
`define WDT_COUNT_ADDR 8'h08

// ----------------------------------------
// Reset control register fields
// ----------------------------------------
`define WDT_IDLE_BIT 2
`define WDT_SLEEP_BIT 3
`define WDT_TIMEOUT_BIT 4
`define WDT_SOFTEN_BIT 5
`define WDT_RSTCTL_RESET 16'h0000

// ----------------------------------------
// Watchdog config word fields
// ----------------------------------------
`define WDT_POST_LSB 0
`define WDT_POST_MSB 3
`define WDT_PRESEL_BIT 4
`define WDT_WINOFF_BIT 6
`define WDT_ALWAYS_ON_BIT 7
`define WDT_CFG_RESET 8'hdf

// ----------------------------------------
// Timing
// ----------------------------------------
`define WDT_SYS_PERIOD_NS 10
`define WDT_RC_PERIOD_NS 31250
`define WDT_RC_CYCLES (`WDT_RC_PERIOD_NS / `WDT_SYS_PERIOD_NS)
`define WDT_BASE_SHORT_US 1000
`define WDT_BASE_LONG_US 4000
`define WDT_PRE_SHORT_MAX 7'h1f
`define WDT_PRE_LONG_MAX 7'h7f

`endif

// ### core/window_watchdog_timer.sv
// Window watchdog timer: reset control flags, config word, postscaler and window check.
// Assumes the CPU core on clk_sys gives one-cycle instruction pulses and takes
// watchdogReset as a request to reset the device.
//
// What this block does
// R1 - Watchdog counts the RC clock; enabling the watchdog switches that clock on.
// R2 - Prescaler divides the 32 kHz clock by 32 or by 128.
// R3 - Prescaler output gives nominal 1 ms or 4 ms base period.
// R4 - Four-bit postscale field in config bits 3:0 selects sixteen ratios.
// R5 - Any device reset clears counter, prescaler and postscaler.
// R6 - A completed clock switch clears counter, prescaler and postscaler.
// R7 - Entering sleep or idle clears counter, prescaler and postscaler.
// R8 - Leaving sleep or idle clears counter, prescaler and postscaler.
// R9 - Clear instruction in normal execution clears all watchdog counts.
// R10 - Watchdog runs in sleep and idle; its timeout wakes the device.
// R11 - Software clears sleep and idle flags after wake; hardware leaves them set.
// R12 - Timeout sets the sticky timeout flag; only software clears it.
// R13 - Always-on config bit set runs the watchdog regardless of soft enable.
// R14 - With always-on clear, watchdog runs only while soft enable is set.
// R15 - Any device reset clears the soft enable bit.
// R16 - In window mode software clears only in the last quarter.
// R17 - In window mode an early clear instruction resets the device.
// R18 - Prescale select 1 means divide by 128, 0 divide by 32.
// R19 - Window disable 1 is non-window mode, 0 is window mode.
// R20 - Postscale 1111 is 1:32768, 1110 is 1:16384, each lower halves.
// R21 - Postscale ratio equals two to the power of the field value.
// R22 - Timeout in normal execution resets the device and sets the flag.
// R23 - Window check compares running count with three quarters of the period.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ns
`include "wdt_regs.svh"

module window_watchdog_timer #(
  parameter logic [7:0] CFG_RESET = `WDT_CFG_RESET,
  parameter int RC_CYCLES = `WDT_RC_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdData,
  // Instruction events from the core
  input wire logic clearInstr,
  input wire logic powerSaveInstr,
  input wire logic powerSaveIdle,
  input wire logic clockSwitchDone,
  input wire logic wakeEvent,
  // Results to the core
  output logic watchdogReset,
  output logic wakeUp,
  output logic rcClockEnable,
  output logic powerSaved
);

  wdt_pkg::wdtState_t s_r;
  wdt_pkg::wdtState_t s_nxt;

  logic preDone;
  logic [6:0] preCount;
  logic enabled;
  logic inRun;
  logic [15:0] postMax;
  logic timeoutHit;
  logic early;
  logic clrOk;
  logic earlyClear;
  logic psEnter;
  logic wakeNow;
  logic resetNow;
  logic clearCounts;

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (RC_CYCLES < 2) begin : g_bad_cycles
    $error("window_watchdog_timer: RC_CYCLES must be at least 2");
  end

  // ----------------------------------------
  // Count arithmetic
  // ----------------------------------------
  // Terminal postscaler count: ratio is two to the power of the field
  function automatic logic [15:0] postLimit(input logic [3:0] post);
    logic [16:0] ratio;
    ratio = 17'h00001 << post; // see R4, see R20, see R21
    return 16'(ratio - 17'h00001);
  endfunction

  // Elapsed RC ticks since the last clear
  function automatic logic [24:0] elapsed(input logic [15:0] post, input logic [6:0] pre,
                                          input logic longSel);
    logic [24:0] val;
    if (longSel) begin
      val = {2'b00, post, pre};
    end else begin
      val = {4'h0, post, pre[4:0]};
    end
    return val;
  endfunction

  // Whole period in RC ticks for the chosen prescale and postscale
  function automatic logic [24:0] period(input logic [3:0] post, input logic longSel);
    logic [24:0] ratio;
    ratio = 25'h0000001 << post;
    return longSel ? (ratio << 7) : (ratio << 5);
  endfunction

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  wdt_prescaler #(
    .RC_CYCLES(RC_CYCLES)
  ) u_prescaler (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .run(enabled),
    .clear(clearCounts),
    .longMode(s_r.cfg[`WDT_PRESEL_BIT]),
    .preDone(preDone),
    .preCount(preCount)
  );

  // ----------------------------------------
  // Event decode
  // ----------------------------------------
  // Run condition, timeout, window check and counter clears
  always_comb begin
    enabled = s_r.cfg[`WDT_ALWAYS_ON_BIT] | s_r.softEnable; // see R13, see R14
    inRun = (s_r.mode == wdt_pkg::PM_RUN);
    postMax = postLimit(s_r.cfg[`WDT_POST_MSB:`WDT_POST_LSB]);
    timeoutHit = enabled & preDone & (s_r.postCnt >= postMax);
    // Early when four times the elapsed count is below three periods
    early = ({1'b0, elapsed(s_r.postCnt, preCount, s_r.cfg[`WDT_PRESEL_BIT]), 2'b00}
             < (28'({3'b000, period(s_r.cfg[`WDT_POST_MSB:`WDT_POST_LSB], s_r.cfg[`WDT_PRESEL_BIT])}) * 28'd3));
    clrOk = clearInstr & inRun;
    earlyClear = clrOk & enabled & ~s_r.cfg[`WDT_WINOFF_BIT] & early; // see R17, see R19, see R23
    psEnter = powerSaveInstr & inRun;
    wakeNow = ~inRun & (wakeEvent | timeoutHit); // see R10
    resetNow = inRun & (timeoutHit | earlyClear); // see R22
    // A disabled watchdog holds its counts at zero
    clearCounts = clockSwitchDone | psEnter | wakeNow | clrOk | resetNow | ~enabled; // see R6, see R7, see R8, see R9
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Register writes first, hardware events after so that a hardware event beats a same-cycle write
  always_comb begin
    s_nxt = s_r;
    s_nxt.resetPulse = 1'b0;
    s_nxt.wakePulse = 1'b0;
    s_nxt.rdData = 16'h0000;
    // Software access to the reset control register and config word
    if (regWr && regAddr == `WDT_RSTCTL_ADDR) begin
      s_nxt.softEnable = regWrData[`WDT_SOFTEN_BIT];
      s_nxt.timeoutFlag = regWrData[`WDT_TIMEOUT_BIT];
      s_nxt.sleepFlag = regWrData[`WDT_SLEEP_BIT]; // see R11
      s_nxt.idleFlag = regWrData[`WDT_IDLE_BIT];
    end
    if (regWr && regAddr == `WDT_CFG_ADDR) begin
      s_nxt.cfg = regWrData[7:0];
    end
    // Postscaler counts prescaler outputs
    if (clearCounts) begin
      s_nxt.postCnt = 16'h0000;
    end else if (preDone) begin
      s_nxt.postCnt = s_r.postCnt + 16'h0001;
    end
    // Timeout flag is sticky
    if (timeoutHit || earlyClear) begin
      s_nxt.timeoutFlag = 1'b1; // see R12
    end
    // Power save entry and exit
    if (psEnter) begin
      s_nxt.mode = powerSaveIdle ? wdt_pkg::PM_IDLE : wdt_pkg::PM_SLEEP;
      if (powerSaveIdle) begin
        s_nxt.idleFlag = 1'b1;
      end else begin
        s_nxt.sleepFlag = 1'b1;
      end
    end
    if (wakeNow) begin
      s_nxt.mode = wdt_pkg::PM_RUN; // see R10
      s_nxt.wakePulse = 1'b1;
    end
    // A watchdog reset is a device reset: soft enable falls
    if (resetNow) begin
      s_nxt.resetPulse = 1'b1;
      s_nxt.softEnable = 1'b0; // see R15
    end
    s_nxt.rcClockOn = enabled; // see R1
    // Read data stands only in the cycle after the read strobe
    if (regRd) begin
      case (regAddr)
        `WDT_RSTCTL_ADDR: begin
          s_nxt.rdData[`WDT_SOFTEN_BIT] = s_r.softEnable;
          s_nxt.rdData[`WDT_TIMEOUT_BIT] = s_r.timeoutFlag;
          s_nxt.rdData[`WDT_SLEEP_BIT] = s_r.sleepFlag;
          s_nxt.rdData[`WDT_IDLE_BIT] = s_r.idleFlag;
        end
        `WDT_CFG_ADDR: begin
          s_nxt.rdData = {8'h00, s_r.cfg};
        end
        `WDT_COUNT_ADDR: begin
          s_nxt.rdData = s_r.postCnt;
        end
        default: begin
          s_nxt.rdData = 16'h0000;
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Constant reset values only
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_r.softEnable <= 1'b0; // see R15
      s_r.timeoutFlag <= 1'b0;
      s_r.sleepFlag <= 1'b0;
      s_r.idleFlag <= 1'b0;
      s_r.cfg <= CFG_RESET;
      s_r.postCnt <= 16'h0000; // see R5
      s_r.mode <= wdt_pkg::PM_RUN;
      s_r.resetPulse <= 1'b0;
      s_r.wakePulse <= 1'b0;
      s_r.rcClockOn <= 1'b0;
      s_r.rdData <= 16'h0000;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign regRdData = s_r.rdData;
  assign watchdogReset = s_r.resetPulse;
  assign wakeUp = s_r.wakePulse;
  assign rcClockEnable = s_r.rcClockOn;
  assign powerSaved = (s_r.mode != wdt_pkg::PM_RUN);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // Early clear in window mode
  sequence sEarlyClear;
    clearInstr && inRun && enabled && !s_r.cfg[`WDT_WINOFF_BIT] && early;
  endsequence

  // Timeout while the core is powered down
  sequence sSleepTimeout;
    !inRun && timeoutHit;
  endsequence

  a_timeout_resets: assert property (inRun && timeoutHit |=> watchdogReset && s_r.timeoutFlag) // see R22
    else $error("normal timeout did not reset and flag");

  a_flag_sticky: assert property (s_r.timeoutFlag && !(regWr && regAddr == `WDT_RSTCTL_ADDR)
                                  |=> s_r.timeoutFlag) // see R12
    else $error("timeout flag cleared without software");

  a_flag_set_wins: assert property (timeoutHit && regWr && regAddr == `WDT_RSTCTL_ADDR
                                    |=> s_r.timeoutFlag) // see R12
    else $error("timeout lost to a same-cycle clear");

  a_early_clear: assert property (sEarlyClear |=> watchdogReset ##1 !watchdogReset) // see R17
    else $error("early window clear did not give one reset pulse");

  a_nowindow_clear: assert property (clrOk && s_r.cfg[`WDT_WINOFF_BIT] && !timeoutHit
                                     |=> !watchdogReset && s_r.postCnt == 16'h0000) // see R9
    else $error("non-window clear misbehaved");

  a_sleep_wake: assert property (sSleepTimeout |=> wakeUp && !watchdogReset && !powerSaved) // see R10
    else $error("sleep timeout did not wake cleanly");

  a_ps_clear: assert property (psEnter |=> s_r.postCnt == 16'h0000 && powerSaved) // see R7
    else $error("power save entry did not clear counts");

  a_wake_clear: assert property (wakeNow |=> s_r.postCnt == 16'h0000 && !powerSaved) // see R8
    else $error("wake did not clear counts");

  a_switch_clear: assert property (clockSwitchDone |=> s_r.postCnt == 16'h0000) // see R6
    else $error("clock switch did not clear counts");

  a_always_on: assert property (s_r.cfg[`WDT_ALWAYS_ON_BIT] |=> rcClockEnable) // see R13
    else $error("always-on watchdog clock stopped");

  a_soft_off: assert property (!s_r.cfg[`WDT_ALWAYS_ON_BIT] && !s_r.softEnable
                               |=> !rcClockEnable && !watchdogReset && s_r.postCnt == 16'h0000) // see R14
    else $error("disabled watchdog still running");

  a_reset_soft: assert property (resetNow |=> !s_r.softEnable) // see R15
    else $error("watchdog reset kept soft enable");

  a_read_once: assert property (regRd ##1 !regRd |=> regRdData == 16'h0000) // see the strobed port note in the header
    else $error("read data held beyond one cycle");

  // Power save entry into idle
  sequence sIdleEntry;
    psEnter && powerSaveIdle;
  endsequence

  // Power save entry into sleep
  sequence sSleepEntry;
    psEnter && !powerSaveIdle;
  endsequence

  a_idle_entry: assert property (sIdleEntry |=> s_r.idleFlag && powerSaved) // see R7
    else $error("idle entry did not flag idle");

  a_sleep_entry: assert property (sSleepEntry |=> s_r.sleepFlag && powerSaved) // see R7
    else $error("sleep entry did not flag sleep");

  // Reset and wake requests are single-cycle pulses
  a_reset_single: assert property (watchdogReset |=> !watchdogReset) // see R22
    else $error("reset request longer than one cycle");

  a_wake_single: assert property (wakeUp |=> !wakeUp) // see R10
    else $error("wake request longer than one cycle");

  // The RC clock follows the run condition one cycle later
  a_rc_follows: assert property (enabled |=> rcClockEnable) // see R1
    else $error("enabled watchdog left the RC clock off");

  // A clear in normal execution always empties the postscaler
  a_clear_counts: assert property (clrOk |=> s_r.postCnt == 16'h0000) // see R9
    else $error("clear instruction left a count");

endmodule

// ### tb/window_watchdog_timer_tb_top.sv
// Self-checking testbench of the window watchdog timer, driving every port directly.
// Assumes the core/ files compiled first and core/ on the include path.
`timescale 1ns/1ns
`include "wdt_regs.svh"

module window_watchdog_timer_tb_top;
  // ----------------------------------------
  // Signals and settings
  // ----------------------------------------
  localparam int RCDIV = 4;
  localparam int BASE = 32 * RCDIV;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWrData = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] regRdData;
  logic clearInstr = 1'b0;
  logic powerSaveInstr = 1'b0;
  logic powerSaveIdle = 1'b0;
  logic clockSwitchDone = 1'b0;
  logic wakeEvent = 1'b0;
  logic watchdogReset;
  logic wakeUp;
  logic rcClockEnable;
  logic powerSaved;
  int n_errors = 0;
  int n_compared = 0;
  logic [15:0] rd;

  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  window_watchdog_timer #(.RC_CYCLES(RCDIV)) u_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .clearInstr(clearInstr),
    .powerSaveInstr(powerSaveInstr), .powerSaveIdle(powerSaveIdle),
    .clockSwitchDone(clockSwitchDone), .wakeEvent(wakeEvent), .watchdogReset(watchdogReset),
    .wakeUp(wakeUp), .rcClockEnable(rcClockEnable), .powerSaved(powerSaved));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic doReset();
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
  endtask

  task automatic regWrite(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  task automatic regRead(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask

  // One-cycle event: 0 clear, 1 power save, 2 clock switch, 3 wake
  task automatic pulse(input int k);
    @(posedge clk_sys);
    clearInstr <= (k == 0);
    powerSaveInstr <= (k == 1);
    clockSwitchDone <= (k == 2);
    wakeEvent <= (k == 3);
    @(posedge clk_sys);
    clearInstr <= 1'b0;
    powerSaveInstr <= 1'b0;
    clockSwitchDone <= 1'b0;
    wakeEvent <= 1'b0;
  endtask

  // Counts cycles up to a reset or wake pulse and judges span and kind
  task automatic waitEvt(input int e, input logic expWake);
    int c;
    c = 0;
    #1;
    while (watchdogReset !== 1'b1 && wakeUp !== 1'b1 && c < 20000) begin
      @(posedge clk_sys);
      #1;
      c++;
    end
    chk("event span in range", 16'h0001, 16'((c >= e - 6) && (c <= e + 6)));
    chk("reset and wake", {14'h0, ~expWake, expWake}, {14'h0, watchdogReset, wakeUp});
  endtask

  task automatic noReset(input int k);
    logic seen;
    seen = 1'b0;
    repeat (k) begin
      #1;
      if (watchdogReset !== 1'b0) seen = 1'b1;
      @(posedge clk_sys);
    end
    chk("no reset pulse", 16'h0000, {15'h0, seen});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic testReset();
    regWrite(`WDT_CFG_ADDR, 16'h0040);
    regWrite(`WDT_RSTCTL_ADDR, 16'h0020);
    doReset();
    regRead(`WDT_RSTCTL_ADDR, rd);
    chk("reset control after reset", `WDT_RSTCTL_RESET, rd);
    regRead(`WDT_CFG_ADDR, rd);
    chk("cfg after reset", 16'h00df, rd);
    regRead(8'h20, rd);
    chk("unmapped read", 16'h0000, rd);
    chk("rc clock on", 16'h0001, {15'h0, rcClockEnable});
    $display("test reset done");
  endtask

  task automatic testScale();
    for (int p = 0; p < 5; p++) begin
      regWrite(`WDT_CFG_ADDR, (p == 4) ? 16'h00d0 : (16'h00c0 | 16'(p)));
      pulse(0);
      waitEvt((p == 4) ? 4 * BASE : BASE << p, 1'b0);
    end
    regRead(`WDT_RSTCTL_ADDR, rd);
    chk("timeout flag set", 16'h0010, rd & 16'h0010);
    regRead(`WDT_RSTCTL_ADDR, rd);
    chk("timeout flag kept", 16'h0010, rd & 16'h0010);
    regWrite(`WDT_RSTCTL_ADDR, 16'h0000);
    regRead(`WDT_RSTCTL_ADDR, rd);
    chk("timeout flag cleared", 16'h0000, rd & 16'h0010);
    $display("test scale done");
  endtask

  task automatic testSoft();
    regWrite(`WDT_CFG_ADDR, 16'h0040);
    regWrite(`WDT_RSTCTL_ADDR, 16'h0000);
    noReset(300);
    chk("rc clock off", 16'h0000, {15'h0, rcClockEnable});
    regWrite(`WDT_RSTCTL_ADDR, 16'h0020);
    waitEvt(BASE, 1'b0);
    regWrite(`WDT_CFG_ADDR, 16'h00c0);
    regWrite(`WDT_RSTCTL_ADDR, 16'h0000);
    @(posedge clk_sys);
    #1 chk("always on", 16'h0001, {15'h0, rcClockEnable});
    $display("test soft done");
  endtask

  task automatic testWindow();
    regWrite(`WDT_CFG_ADDR, 16'h0080);
    pulse(2);
    pulse(0);
    waitEvt(1, 1'b0);
    repeat (112) @(posedge clk_sys);
    pulse(0);
    noReset(20);
    repeat (55) @(posedge clk_sys);
    pulse(0);
    waitEvt(1, 1'b0);
    $display("test window done");
  endtask

  task automatic testSleep();
    regWrite(`WDT_CFG_ADDR, 16'h00c0);
    regWrite(`WDT_RSTCTL_ADDR, 16'h0000);
    pulse(1);
    #1 chk("sleeping", 16'h0001, {15'h0, powerSaved});
    waitEvt(BASE, 1'b1);
    chk("awake", 16'h0000, {15'h0, powerSaved});
    regRead(`WDT_RSTCTL_ADDR, rd);
    chk("sleep flags", 16'h0018, rd);
    regWrite(`WDT_RSTCTL_ADDR, 16'h0000);
    @(posedge clk_sys);
    powerSaveIdle <= 1'b1;
    pulse(1);
    regRead(`WDT_RSTCTL_ADDR, rd);
    chk("idle flag", 16'h0004, rd);
    repeat (50) @(posedge clk_sys);
    pulse(3);
    waitEvt(1, 1'b1);
    // Let the wake pulse end before timing the next period
    @(posedge clk_sys);
    waitEvt(BASE, 1'b0);
    regWrite(`WDT_RSTCTL_ADDR, 16'h0000);
    $display("test sleep done");
  endtask

  task automatic testClears();
    regWrite(`WDT_CFG_ADDR, 16'h00c0);
    pulse(0);
    repeat (90) @(posedge clk_sys);
    pulse(2);
    waitEvt(BASE, 1'b0);
    repeat (90) @(posedge clk_sys);
    pulse(0);
    waitEvt(BASE, 1'b0);
    $display("test clears done");
  endtask

  // ----------------------------------------
  // Verdict, main sequence and watchdog
  // ----------------------------------------
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    doReset();
    testReset();
    testScale();
    testSoft();
    testWindow();
    testSleep();
    testClears();
    results();
  end

  // Hang guard, well past the expected run
  initial begin
    #900000;
    n_errors++;
    $display("[ERR] run time expected finished seen hung");
    results();
  end
endmodule
